// file: pan_map.svh
`ifndef PAN_MAP_SVH
`define PAN_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PAN_OFS_PARTNER    5'h05
`define PAN_OFS_EXPANSION  5'h06
`define PAN_OFS_VENDOR     5'h10

// ----------------------------------------------------------------
// Partner ability fields
// ----------------------------------------------------------------
`define PAN_LP_NEXT_PAGE   15
`define PAN_LP_ACK         14
`define PAN_LP_FAULT       13
`define PAN_LP_RSV_HI      12
`define PAN_LP_RSV_LO      11
`define PAN_LP_FLOW        10
`define PAN_LP_T4          9
`define PAN_LP_FAST_FULL   8
`define PAN_LP_FAST_HALF   7
`define PAN_LP_TEN_FULL    6
`define PAN_LP_TEN_HALF    5
`define PAN_LP_SEL_HI      4
`define PAN_LP_SEL_LO      0
`define PAN_PARTNER_MASK   16'he7ff

// ----------------------------------------------------------------
// Expansion fields
// ----------------------------------------------------------------
`define PAN_EX_RSV_HI      15
`define PAN_EX_RSV_LO      5
`define PAN_EX_PD_FAULT    4
`define PAN_EX_LP_PAGE     3
`define PAN_EX_LOCAL_PAGE  2
`define PAN_EX_PAGE_RX     1
`define PAN_EX_LP_NEG      0
`define PAN_LOCAL_PAGE_VAL 1'h0

// ----------------------------------------------------------------
// Vendor configuration fields (stored slice is bits 15..8)
// ----------------------------------------------------------------
`define PAN_VC_HI          15
`define PAN_VC_LO          8
`define PAN_VC_CODE_BP     7
`define PAN_VC_SCR_BP      6
`define PAN_VC_ALIGN_BP    5
`define PAN_VC_FORCE_SD    4
`define PAN_VC_REPEATER    3
`define PAN_VC_FAST        2
`define PAN_VC_RSV         1
`define PAN_VC_RMII        0
`define PAN_VC_BYPASS_RST  4'h0
`define PAN_VC_FAST_RST    1'h1
`define PAN_VC_RSV_RST     1'h0
`define PAN_VC_LOW_READ    8'h00

`define PAN_ZERO16         16'h0000

`endif

// file: pan_pkg.sv
package pan_pkg;

   typedef logic [15:0] pan_word_t;
   typedef logic [4:0]  pan_addr_t;
   typedef logic [7:0]  pan_vendor_t;

endpackage : pan_pkg

// file: pan_flag_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pan_flag_if;
   logic set;
   logic clr;
   logic q;

   modport owner (input set, input clr, output q);
   modport user  (output set, output clr, input q);
endinterface : pan_flag_if

`default_nettype wire

// file: pan_flag.sv
`timescale 1ns/1ps
`default_nettype none

module pan_flag (
   input  wire logic   mclk,
   input  wire logic   nrst,
   pan_flag_if.owner   fl
);

   // ----------------------------------------------------------------
   // Latch-high flag
   // ----------------------------------------------------------------
   // Set is checked first so an event in the clearing cycle survives
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         fl.q <= 1'b0;
      end else if (fl.set) begin
         fl.q <= 1'b1;
      end else if (fl.clr) begin
         fl.q <= 1'b0;
      end
   end

   a_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
      fl.set |=> fl.q)
      else $error("latched flag lost its setting event");

   a_clear_only: assert property (@(posedge mclk) disable iff (!nrst)
      fl.clr && !fl.set |=> !fl.q)
      else $error("latched flag not cleared");

endmodule : pan_flag

`default_nettype wire

// file: pan_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pan_map.svh"


module pan_regs (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire pan_pkg::pan_addr_t reg_addr,
   input  wire pan_pkg::pan_word_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  pan_pkg::pan_word_t reg_rdata,
   input  wire pan_pkg::pan_word_t an_word,
   input  wire logic              an_word_valid,
   input  wire logic              an_page_event,
   input  wire logic              an_pd_fault,
   input  wire logic              partner_local_extra_page_capable,
   input  wire logic              partner_an_able,
   input  wire logic              strap_repeater,
   input  wire logic              strap_rmii,
   input  wire logic              signal_detect_raw,
   output logic                   block_code_bypass,
   output logic                   whitening_bypass,
   output logic                   symbol_framing_bypass,
   output logic                   signal_detect,
   output logic                   repeater_mode,
   output logic                   fast_mode,
   output logic                   rmii_mode
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Not reset, so the strap levels are already settled by the time
   // a held reset releases and the vendor bits take them.
   logic [1:0] rep_sync;
   logic [1:0] rmii_sync;
   logic [1:0] sd_sync;

   always_ff @(posedge mclk) begin
      rep_sync  <= {rep_sync[0], strap_repeater};
      rmii_sync <= {rmii_sync[0], strap_rmii};
      sd_sync   <= {sd_sync[0], signal_detect_raw};
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire sel_partner   = (reg_addr == `PAN_OFS_PARTNER);
   wire sel_expansion = (reg_addr == `PAN_OFS_EXPANSION);
   wire sel_vendor    = (reg_addr == `PAN_OFS_VENDOR);
   wire exp_read      = reg_rd && sel_expansion;
   wire vendor_write  = reg_wr && sel_vendor;

   // ----------------------------------------------------------------
   // Partner ability register
   // ----------------------------------------------------------------
   pan_pkg::pan_word_t partner_ability_reg;
   pan_pkg::pan_word_t next_partner;

   // Reserved bits are masked at load so they can never read as 1
   assign next_partner = an_word_valid
                       ? (an_word & `PAN_PARTNER_MASK)
                       : partner_ability_reg;

   // Whole word, acknowledge included, comes from the negotiation side
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         partner_ability_reg <= `PAN_ZERO16;
      end else begin
         partner_ability_reg <= next_partner;
      end
   end

   wire next_page_flag       = partner_ability_reg[`PAN_LP_NEXT_PAGE];
   wire partner_ack_flag     = partner_ability_reg[`PAN_LP_ACK];
   wire remote_fault_flag    = partner_ability_reg[`PAN_LP_FAULT];
   wire partner_flow_control = partner_ability_reg[`PAN_LP_FLOW];
   wire partner_t4_ability   = partner_ability_reg[`PAN_LP_T4];
   wire fast_full_duplex_ability = partner_ability_reg[`PAN_LP_FAST_FULL];
   wire fast_half_duplex_ability = partner_ability_reg[`PAN_LP_FAST_HALF];
   wire ten_full_duplex_ability  = partner_ability_reg[`PAN_LP_TEN_FULL];
   wire ten_half_duplex_ability  = partner_ability_reg[`PAN_LP_TEN_HALF];

   // ----------------------------------------------------------------
   // Expansion register
   // ----------------------------------------------------------------
   logic partner_extra_page_capable;
   logic partner_negotiation_capable;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         partner_extra_page_capable  <= 1'b0;
         partner_negotiation_capable <= 1'b0;
      end else begin
         partner_extra_page_capable  <= partner_local_extra_page_capable;
         partner_negotiation_capable <= partner_an_able;
      end
   end

   pan_flag_if pdf_if ();
   pan_flag_if page_if ();

   assign pdf_if.set  = an_pd_fault;
   assign pdf_if.clr  = exp_read;
   assign page_if.set = an_page_event;
   assign page_if.clr = exp_read;

   pan_flag u_pdf_flag (
      .mclk (mclk),
      .nrst (nrst),
      .fl   (pdf_if.owner)
   );

   pan_flag u_page_flag (
      .mclk (mclk),
      .nrst (nrst),
      .fl   (page_if.owner)
   );

   wire parallel_detect_fault     = pdf_if.q;
   wire page_received             = page_if.q;
   wire local_extra_page_capable  = `PAN_LOCAL_PAGE_VAL;

   pan_pkg::pan_word_t negotiation_expansion_reg;

   always_comb begin
      negotiation_expansion_reg = `PAN_ZERO16;
      negotiation_expansion_reg[`PAN_EX_PD_FAULT]   = parallel_detect_fault;
      negotiation_expansion_reg[`PAN_EX_LP_PAGE]    =
         partner_extra_page_capable;
      negotiation_expansion_reg[`PAN_EX_LOCAL_PAGE] =
         local_extra_page_capable;
      negotiation_expansion_reg[`PAN_EX_PAGE_RX]    = page_received;
      negotiation_expansion_reg[`PAN_EX_LP_NEG]     =
         partner_negotiation_capable;
   end

   // ----------------------------------------------------------------
   // Vendor configuration register
   // ----------------------------------------------------------------
   // Only bits 15..8 are implemented; the low byte reads as zero.
   pan_pkg::pan_vendor_t vendor_hi;
   pan_pkg::pan_vendor_t next_vendor;
   pan_pkg::pan_vendor_t vendor_reset;
   pan_pkg::pan_word_t   vendor_config_reg;

   assign vendor_reset = {`PAN_VC_BYPASS_RST,
                          rep_sync[1],
                          `PAN_VC_FAST_RST,
                          `PAN_VC_RSV_RST,
                          rmii_sync[1]};

   assign next_vendor = !nrst        ? vendor_reset
                      : vendor_write ? reg_wdata[`PAN_VC_HI:`PAN_VC_LO]
                      : vendor_hi;

   // Synchronous reset reloads the straps each cycle it is held
   always_ff @(posedge mclk) begin
      vendor_hi <= next_vendor;
   end

   assign vendor_config_reg = {vendor_hi, `PAN_VC_LOW_READ};

   wire next_align_bp = next_vendor[`PAN_VC_ALIGN_BP];
   wire next_code_bp  = next_vendor[`PAN_VC_CODE_BP] | next_align_bp;
   wire next_scr_bp   = next_vendor[`PAN_VC_SCR_BP] | next_align_bp;
   wire next_sd       = sd_sync[1] | next_vendor[`PAN_VC_FORCE_SD];

   // ----------------------------------------------------------------
   // Control outputs
   // ----------------------------------------------------------------
   // Registered from the next vendor value so they move with the bits
   always_ff @(posedge mclk) begin
      block_code_bypass     <= next_code_bp;
      whitening_bypass      <= next_scr_bp;
      symbol_framing_bypass <= next_align_bp;
      signal_detect         <= next_sd;
      repeater_mode         <= next_vendor[`PAN_VC_REPEATER];
      fast_mode             <= next_vendor[`PAN_VC_FAST];
      rmii_mode             <= next_vendor[`PAN_VC_RMII];
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Data stands for one cycle only; unmapped offsets answer zero.
   pan_pkg::pan_word_t read_mux;
   pan_pkg::pan_word_t next_rdata;

   assign read_mux = sel_partner   ? partner_ability_reg
                   : sel_expansion ? negotiation_expansion_reg
                   : sel_vendor    ? vendor_config_reg
                   : `PAN_ZERO16;

   assign next_rdata = reg_rd ? read_mux : `PAN_ZERO16;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         reg_rdata <= `PAN_ZERO16;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_fault_seen;
      an_pd_fault;
   endsequence

   sequence s_no_clear_2;
      !exp_read [*2];
   endsequence

   sequence s_page_read;
      exp_read && !an_page_event;
   endsequence

   sequence s_page_seen;
      an_page_event;
   endsequence

   a_partner_load: assert property (
      an_word_valid |=>
         partner_ability_reg == ($past(an_word) & `PAN_PARTNER_MASK))
      else $error("partner ability word not loaded");

   a_partner_ro: assert property (
      reg_wr && sel_partner && !an_word_valid |=>
         $stable(partner_ability_reg))
      else $error("write changed partner ability register");

   a_partner_bits: assert property (
      $past(an_word_valid) |->
         next_page_flag == $past(an_word[`PAN_LP_NEXT_PAGE]) &&
         partner_ack_flag == $past(an_word[`PAN_LP_ACK]) &&
         remote_fault_flag == $past(an_word[`PAN_LP_FAULT]) &&
         partner_flow_control == $past(an_word[`PAN_LP_FLOW]))
      else $error("partner flag bits mismatch");

   a_partner_abilities: assert property (
      $past(an_word_valid) |->
         partner_t4_ability == $past(an_word[`PAN_LP_T4]) &&
         fast_full_duplex_ability == $past(an_word[`PAN_LP_FAST_FULL]) &&
         fast_half_duplex_ability == $past(an_word[`PAN_LP_FAST_HALF]) &&
         ten_full_duplex_ability == $past(an_word[`PAN_LP_TEN_FULL]) &&
         ten_half_duplex_ability == $past(an_word[`PAN_LP_TEN_HALF]))
      else $error("partner ability bits mismatch");

   a_reserved_zero: assert property (
      partner_ability_reg[`PAN_LP_RSV_HI:`PAN_LP_RSV_LO] == 2'h0 &&
      negotiation_expansion_reg[`PAN_EX_RSV_HI:`PAN_EX_RSV_LO] == 11'h000)
      else $error("reserved bits not zero");

   a_fault_sticky: assert property (
      s_fault_seen ##1 s_no_clear_2 |=> parallel_detect_fault)
      else $error("parallel detect fault not held");

   a_page_sticky: assert property (
      s_page_seen ##1 s_no_clear_2 |=> page_received)
      else $error("new page flag not held");

   a_page_clear: assert property (
      s_page_read |=> !page_received)
      else $error("page flag not cleared by read");

   a_read_before_clear: assert property (
      exp_read && page_received |=> reg_rdata[`PAN_EX_PAGE_RX])
      else $error("read lost the latched page flag");

   a_local_page_zero: assert property (
      !local_extra_page_capable)
      else $error("local extra page bit set");

   a_partner_caps: assert property (
      $past(nrst) |->
         partner_negotiation_capable == $past(partner_an_able) &&
         partner_extra_page_capable == $past(partner_local_extra_page_capable))
      else $error("partner capability bits stale");

   a_vendor_reset: assert property (
      $rose(nrst) |->
         vendor_hi[`PAN_VC_FAST] && fast_mode &&
         vendor_hi[`PAN_VC_CODE_BP:`PAN_VC_FORCE_SD] == 4'h0 &&
         repeater_mode == $past(rep_sync[1]) &&
         rmii_mode == $past(rmii_sync[1]))
      else $error("vendor register reset value wrong");

   a_vendor_write: assert property (
      vendor_write |=>
         vendor_hi == $past(reg_wdata[`PAN_VC_HI:`PAN_VC_LO]) &&
         repeater_mode == $past(reg_wdata[`PAN_VC_LO + `PAN_VC_REPEATER]))
      else $error("vendor write not applied");

   a_align_bypass: assert property (
      symbol_framing_bypass |-> block_code_bypass && whitening_bypass)
      else $error("alignment bypass left coding active");

   a_code_bypass: assert property (
      vendor_hi[`PAN_VC_CODE_BP] |-> block_code_bypass)
      else $error("block code bypass not applied");

   a_scr_bypass: assert property (
      vendor_hi[`PAN_VC_SCR_BP] |-> whitening_bypass)
      else $error("scrambler bypass not applied");

   a_force_sd: assert property (
      vendor_hi[`PAN_VC_FORCE_SD] |-> signal_detect)
      else $error("signal detect not forced");

   a_mode_outputs: assert property (
      repeater_mode == vendor_hi[`PAN_VC_REPEATER] &&
      fast_mode == vendor_hi[`PAN_VC_FAST] &&
      rmii_mode == vendor_hi[`PAN_VC_RMII])
      else $error("mode outputs differ from vendor bits");

   a_read_pulse: assert property (
      !reg_rd |=> reg_rdata == `PAN_ZERO16)
      else $error("read data outside its cycle");

endmodule : pan_regs

`default_nettype wire

// file: pan_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Management controller: single-cycle strobes, no wait states
// ----------------------------------------------------------------
module pan_mgmt_model (
   input  wire logic               mclk,
   output var  pan_pkg::pan_addr_t reg_addr,
   output var  pan_pkg::pan_word_t reg_wdata,
   output var  logic               reg_wr,
   output var  logic               reg_rd,
   input  wire pan_pkg::pan_word_t reg_rdata
);
   initial begin
      reg_addr  = 5'h00;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // Idle bus shows the inverse of the last value so stale data never helps
   // Ordinary traffic never aims at the acknowledge bit
   task automatic wr(input pan_pkg::pan_addr_t a,
                     input pan_pkg::pan_word_t d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input pan_pkg::pan_addr_t a,
                     output pan_pkg::pan_word_t d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge mclk);
      d = reg_rdata;
   endtask : rd
endmodule : pan_mgmt_model

`default_nettype wire

// file: phy_autoneg_status_and_debug_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pan_map.svh"

module phy_autoneg_status_and_debug_regs_tb_top;
   logic               mclk = 1'b0;
   logic               nrst = 1'b0;
   pan_pkg::pan_addr_t reg_addr;
   pan_pkg::pan_word_t reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   pan_pkg::pan_word_t reg_rdata;
   pan_pkg::pan_word_t an_word = 16'h0000;
   logic               an_word_valid = 1'b0;
   logic               an_page_event = 1'b0;
   logic               an_pd_fault = 1'b0;
   logic               partner_local_extra_page_capable = 1'b0;
   logic               partner_an_able = 1'b0;
   logic               strap_repeater = 1'b1;
   logic               strap_rmii = 1'b0;
   logic               signal_detect_raw = 1'b0;
   wire  [6:0]         outs;
   int                 errors = 0;
   int                 n_tests = 0;

   always #20 mclk = ~mclk;

   pan_mgmt_model u_mgmt (.mclk(mclk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   pan_regs dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .an_word(an_word),
      .an_word_valid(an_word_valid), .an_page_event(an_page_event),
      .an_pd_fault(an_pd_fault), .partner_local_extra_page_capable(partner_local_extra_page_capable),
      .partner_an_able(partner_an_able),
      .strap_repeater(strap_repeater), .strap_rmii(strap_rmii),
      .signal_detect_raw(signal_detect_raw),
      .block_code_bypass(outs[6]), .whitening_bypass(outs[5]),
      .symbol_framing_bypass(outs[4]), .signal_detect(outs[3]),
      .repeater_mode(outs[2]), .fast_mode(outs[1]),
      .rmii_mode(outs[0]));

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input pan_pkg::pan_word_t seen,
                      input pan_pkg::pan_word_t exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic rd_chk(input string nm, input pan_pkg::pan_addr_t a,
                         input pan_pkg::pan_word_t exp);
      pan_pkg::pan_word_t d;
      u_mgmt.rd(a, d);
      chk(nm, d, exp);
   endtask : rd_chk

   task automatic load(input pan_pkg::pan_word_t w);
      @(posedge mclk);
      an_word       <= w;
      an_word_valid <= 1'b1;
      @(posedge mclk);
      an_word_valid <= 1'b0;
      an_word       <= ~w;
   endtask : load

   task automatic ev(input logic f, input logic p);
      @(posedge mclk);
      an_pd_fault   <= f;
      an_page_event <= p;
      @(posedge mclk);
      an_pd_fault   <= 1'b0;
      an_page_event <= 1'b0;
   endtask : ev

   task automatic do_reset(input logic rep, input logic rm);
      @(posedge mclk);
      nrst           <= 1'b0;
      strap_repeater <= rep;
      strap_rmii     <= rm;
      // The partner drops out while the port is held in reset
      partner_local_extra_page_capable <= 1'b0;
      partner_an_able <= 1'b0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
   endtask : do_reset

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values(input pan_pkg::pan_word_t vend);
      @(negedge mclk);
      chk("outs_rst", {9'h000, outs},
          {13'h0000, vend[11:10], vend[8]});
      rd_chk("partner_rst", `PAN_OFS_PARTNER, 16'h0000);
      rd_chk("expan_rst", `PAN_OFS_EXPANSION, 16'h0000);
      rd_chk("vendor_rst", `PAN_OFS_VENDOR, vend);
   endtask : t_reset_values

   task automatic t_partner_load();
      pan_pkg::pan_word_t w;
      // Walking one shows each ability lands on its own bit
      for (int i = 0; i < 16; i++) begin
         w = 16'h0001 << i;
         load(w);
         rd_chk("partner_bit", `PAN_OFS_PARTNER, w & 16'he7ff);
      end
      load(16'hffff);
      rd_chk("partner_all", `PAN_OFS_PARTNER, 16'he7ff);
      u_mgmt.wr(`PAN_OFS_PARTNER, 16'h0000);
      rd_chk("partner_ro", `PAN_OFS_PARTNER, 16'he7ff);
      load(16'h4000);
      rd_chk("partner_ack", `PAN_OFS_PARTNER, 16'h4000);
   endtask : t_partner_load

   task automatic t_expansion();
      @(posedge mclk);
      partner_local_extra_page_capable <= 1'b1;
      partner_an_able <= 1'b1;
      rd_chk("expan_able", `PAN_OFS_EXPANSION, 16'h0009);
      ev(1'b1, 1'b0);
      repeat (5) @(posedge mclk);
      rd_chk("expan_fault", `PAN_OFS_EXPANSION, 16'h0019);
      rd_chk("expan_fclr", `PAN_OFS_EXPANSION, 16'h0009);
      ev(1'b0, 1'b1);
      u_mgmt.wr(`PAN_OFS_EXPANSION, 16'hffff);
      rd_chk("expan_page", `PAN_OFS_EXPANSION, 16'h000b);
      rd_chk("expan_pclr", `PAN_OFS_EXPANSION, 16'h0009);
      @(posedge mclk);
      partner_local_extra_page_capable <= 1'b0;
      rd_chk("expan_np0", `PAN_OFS_EXPANSION, 16'h0001);
      @(negedge mclk);
      chk("rdata_stands", reg_rdata, 16'h0000);
   endtask : t_expansion

   task automatic t_coincident();
      pan_pkg::pan_word_t d;
      fork
         u_mgmt.rd(`PAN_OFS_EXPANSION, d);
         ev(1'b1, 1'b1);
      join
      chk("expan_same", d, 16'h0001);
      rd_chk("expan_kept", `PAN_OFS_EXPANSION, 16'h0013);
      rd_chk("expan_gone", `PAN_OFS_EXPANSION, 16'h0001);
   endtask : t_coincident

   task automatic t_vendor();
      pan_pkg::pan_word_t wv [9] = '{16'h8000, 16'h4000, 16'h2000,
         16'h1000, 16'h0800, 16'h0400, 16'h0100, 16'hffff, 16'h0200};
      logic [6:0]         ov [9] = '{7'h40, 7'h20, 7'h70, 7'h08,
         7'h04, 7'h02, 7'h01, 7'h7f, 7'h00};
      for (int i = 0; i < 9; i++) begin
         u_mgmt.wr(`PAN_OFS_VENDOR, wv[i]);
         @(negedge mclk);
         chk("vendor_outs", {9'h000, outs}, {9'h000, ov[i]});
         rd_chk("vendor_rb", `PAN_OFS_VENDOR, wv[i] & 16'hff00);
      end
      u_mgmt.wr(5'h11, 16'hffff);
      rd_chk("unmapped_rd", 5'h07, 16'h0000);
      rd_chk("unmapped_wr", `PAN_OFS_VENDOR, 16'h0200);
   endtask : t_vendor

   task automatic t_detect();
      @(posedge mclk);
      signal_detect_raw <= 1'b1;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk("detect_pin", {15'h0000, outs[3]}, 16'h0001);
      @(posedge mclk);
      signal_detect_raw <= 1'b0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk("detect_off", {15'h0000, outs[3]}, 16'h0000);
   endtask : t_detect

   // ----------------------------------------------------------------
   // Sequence, verdict and watchdog
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   initial begin
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      t_reset_values(16'h0c00);
      t_partner_load();
      t_expansion();
      t_coincident();
      t_vendor();
      t_detect();
      // Mid-run reset with straps flipped must reload them
      do_reset(1'b0, 1'b1);
      t_reset_values(16'h0500);
      conclude();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      conclude();
   end
endmodule : phy_autoneg_status_and_debug_regs_tb_top

`default_nettype wire
